// ### hw/kcsb_defs.vh
// Purpose: Constants for the keyboard command and scan buffer block
// Assumes: Included by every design file of the block
// Notes:   Times are in microseconds; cycle counts derive from them
`ifndef KCSB_DEFS_VH
`define KCSB_DEFS_VH

// ----------------------------------------
// Host command bytes
// ----------------------------------------
`define KCSB_CMD_LEDS     8'hED
`define KCSB_CMD_ECHO     8'hEE
`define KCSB_CMD_BAD0     8'hEF
`define KCSB_CMD_SETSEL   8'hF0
`define KCSB_CMD_BAD1     8'hF1
`define KCSB_CMD_IDENT    8'hF2
`define KCSB_CMD_RATE     8'hF3
`define KCSB_CMD_ENABLE   8'hF4
`define KCSB_CMD_DEFDIS   8'hF5
`define KCSB_CMD_DEFAULT  8'hF6
`define KCSB_CMD_ALL_LO   8'hF7
`define KCSB_CMD_TYPE_HI  8'hFD
`define KCSB_CMD_RESEND   8'hFE
`define KCSB_CMD_RESET    8'hFF

// ----------------------------------------
// Device response bytes and option byte values
// ----------------------------------------
`define KCSB_RSP_ACK      8'hFA
`define KCSB_RSP_PASS     8'hAA
`define KCSB_RSP_FAIL     8'hFC
`define KCSB_RSP_ECHO     8'hEE
`define KCSB_RSP_RESEND   8'hFE
`define KCSB_OVR_SET1     8'hFF
`define KCSB_OVR_SET23    8'h00
`define KCSB_OPT_QUERY    8'h00
`define KCSB_OPT_SET_MAX  8'h03

// ----------------------------------------
// Defaults and field positions
// ----------------------------------------
`define KCSB_RATE_DEF     7'h2B
`define KCSB_SET_DEF      2'h2
`define KCSB_SET_ONE      2'h1
`define KCSB_DELAY_MSB    6
`define KCSB_DELAY_LSB    5
`define KCSB_EXP_MSB      4
`define KCSB_EXP_LSB      3
`define KCSB_MANT_MSB     2
`define KCSB_MANT_BASE    32'h8

// ----------------------------------------
// Control states
// ----------------------------------------
`define KCSB_ST_POR       3'h0
`define KCSB_ST_BIST      3'h1
`define KCSB_ST_RUN       3'h2
`define KCSB_ST_OPT       3'h3
`define KCSB_ST_RSTW      3'h4

`endif

// ### hw/kcsb_fifo.v
// Purpose: Scan-code byte queue taking up to three bytes per cycle
// Assumes: Writer never pushes more than the free space
// Notes:   Lane 0 is the oldest byte of a push
`timescale 1ns/1ps
`include "kcsb_defs.vh"

module kcsb_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire               clk,
  input  wire               rst_n,
  input  wire               flush,
  input  wire [3*WIDTH-1:0] wrData,
  input  wire [1:0]         wrCnt,
  input  wire               rdEn,
  output wire [WIDTH-1:0]   rdData,
  output wire               empty,
  output wire [AW:0]        count
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    rdPtr_reg;
  reg  [AW-1:0]    wrPtr_reg;
  reg  [AW:0]      count_reg;
  wire [AW-1:0]    laneAddr [0:2];
  wire [2:0]       laneEn;
  integer          i;

  // ----------------------------------------
  // Lane addresses
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gLane
      localparam [AW-1:0] LANE_OFS = g;
      localparam [1:0]    LANE_NUM = g;
      assign laneAddr[g] = wrPtr_reg + LANE_OFS;
      assign laneEn[g]   = (wrCnt > LANE_NUM);
    end
  endgenerate

  always @(posedge clk) begin
    for (i = 0; i < 3; i = i + 1) begin
      if (laneEn[i] && !flush) begin
        mem[laneAddr[i]] <= wrData[i*WIDTH +: WIDTH];
      end
    end
  end

  // ----------------------------------------
  // Pointers and fill level
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPtr_reg <= {AW{1'b0}};
      wrPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else if (flush) begin
      rdPtr_reg <= {AW{1'b0}};
      wrPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      wrPtr_reg <= wrPtr_reg + {{(AW-2){1'b0}}, wrCnt};
      rdPtr_reg <= rdPtr_reg + {{(AW-1){1'b0}}, (rdEn && !empty)};
      count_reg <= count_reg + {{(AW-1){1'b0}}, wrCnt}
                 - {{AW{1'b0}}, (rdEn && !empty)};
    end
  end

  assign rdData = mem[rdPtr_reg];
  assign empty  = (count_reg == {(AW+1){1'b0}});
  assign count  = count_reg;

endmodule // kcsb_fifo

// ### hw/kcsb_keyboard_cmd.v
// Purpose: Keyboard scan queue, typematic, self-test and command logic
// Assumes: Byte transceiver on clk; key events from scan logic on clk
// Notes:   Link clock/data pins only watched for reset acceptance
`timescale 1ns/1ps
`include "kcsb_defs.vh"

// Function
// - Sixteen-byte queue; overflow stores overrun code, drops keys until overrun code sent
// - Command responses bypass the scan-code queue
// - Multi-byte keystroke queued only if it fits, else discarded with overrun
// - Non-pause keys send make on press and break on release
// - Held key repeats after programmable delay at programmable rate
// - Only the last pressed key repeats; stops when it is released
// - While transmission inhibited, held key queues only its first make
// - Power-on reset phase lasts between 150 ms and 2 s
// - Self-test ignores the link, lights LEDs, lasts 300 to 500 ms
// - Pass sends AA and scans; fail sends error code and stays disabled
// - Completion code timing after power-on and after reset command
// - Host command byte encodings ED through FF
// - Commands accepted any time and answered quickly, except during test/reset
// - Default disable acks, flushes, restores default typematic rate (scan set kept), forgets repeat, stops scanning
// - Echo answers EE with no acknowledge, scanning state kept
// - Enable acks, flushes, forgets repeat key, starts scanning
// - EF and F1 answer resend code only, nothing else changes
// - Identify acks, pauses scanning, sends two ID bytes back to back
// - Resend repeats last output, skipping a resend code
// - Reset acks, waits for idle-high link 500 us, then self-test, set 2
// - Set select acks, flushes, takes option byte; 00 reports current set
// - Acknowledge is FA; a new command drops an unsent acknowledge
module kcsb_keyboard_cmd #(
  parameter        CYC_PER_US     = 50,
  parameter        POR_US         = 200000,
  parameter        BIST_US        = 400000,
  parameter        ACCEPT_US      = 500,
  parameter        DELAY_UNIT_US  = 250000,
  parameter        PERIOD_UNIT_US = 4170,
  parameter [15:0] ID_CODE        = 16'h5A12 // Arbitrary value
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        keyValid,
  input  wire        keyMake,
  input  wire        keyPause,
  input  wire [7:0]  keyId,
  input  wire [23:0] keySeq,
  input  wire [1:0]  keyLen,
  input  wire        rxValid,
  input  wire [7:0]  rxData,
  output wire        txValid,
  output wire [7:0]  txData,
  input  wire        txReady,
  input  wire        txInhibit,
  input  wire        linkClkIn,
  input  wire        linkDataIn,
  input  wire        bistPass,
  output wire [2:0]  leds,
  output wire        scanEnabled,
  output wire [1:0]  scanSet,
  output wire        selfTestActive
);

  localparam [7:0]  PRE_MAX = CYC_PER_US - 1;
  localparam [19:0] POR_CNT = POR_US;
  localparam [19:0] BIST_CNT = BIST_US;
  localparam [19:0] ACC_CNT = ACCEPT_US;
  localparam [4:0]  DEPTH = 16;

  // ----------------------------------------
  // Link pin synchronisers
  // ----------------------------------------
  reg [2:0] clkSync_reg;
  reg [2:0] dataSync_reg;
  reg       linkIdle_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync_reg  <= 3'h0;
      dataSync_reg <= 3'h0;
      linkIdle_reg <= 1'b0;
    end else begin
      clkSync_reg  <= {clkSync_reg[1:0], linkClkIn};
      dataSync_reg <= {dataSync_reg[1:0], linkDataIn};
      if (clkSync_reg[2] == clkSync_reg[1] && dataSync_reg[2] == dataSync_reg[1]) begin
        linkIdle_reg <= clkSync_reg[2] & dataSync_reg[2];
      end
    end
  end

  // ----------------------------------------
  // Microsecond tick
  // ----------------------------------------
  reg  [7:0] pre_reg;
  wire       usTick = (pre_reg == PRE_MAX);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 8'h00;
    end else begin
      pre_reg <= usTick ? 8'h00 : pre_reg + 8'h01;
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  reg [2:0]  st_reg;
  reg [19:0] stCnt_reg;
  reg        enabled_reg;
  reg [1:0]  set_reg;
  reg [6:0]  rate_reg;
  reg [2:0]  ledState_reg;
  reg [7:0]  optKind_reg;
  reg [23:0] respQ_reg;
  reg [1:0]  respCnt_reg;
  reg        idBusy_reg;
  reg [7:0]  lastOut_reg;
  reg        ovr_reg;
  reg        repValid_reg;
  reg [7:0]  repId_reg;
  reg [23:0] repSeq_reg;
  reg [1:0]  repLen_reg;
  reg [19:0] repCnt_reg;

  // ----------------------------------------
  // Typematic timing from rate byte
  // ----------------------------------------
  wire [31:0] delayUs = ({30'h0, rate_reg[`KCSB_DELAY_MSB:`KCSB_DELAY_LSB]} + 32'h1)
                        * DELAY_UNIT_US;
  wire [31:0] periodUs = ((`KCSB_MANT_BASE + {29'h0, rate_reg[`KCSB_MANT_MSB:0]})
                         << rate_reg[`KCSB_EXP_MSB:`KCSB_EXP_LSB]) * PERIOD_UNIT_US;

  // ----------------------------------------
  // Queue and transmit path
  // ----------------------------------------
  wire       fifoEmpty;
  wire [4:0] fifoCount;
  wire [7:0] fifoData;
  reg        flush;
  reg [23:0] pushData;
  reg [1:0]  pushCnt;
  reg        keyOvr;
  reg [23:0] wantSeq;
  reg [1:0]  wantLen;

  wire [7:0] ovrCode = (set_reg == `KCSB_SET_ONE) ? `KCSB_OVR_SET1 : `KCSB_OVR_SET23;
  wire       respOut = (respCnt_reg != 2'h0);
  wire       scanOn = (st_reg == `KCSB_ST_RUN) && enabled_reg && !idBusy_reg;
  wire       cmdIn = rxValid && (st_reg != `KCSB_ST_POR) && (st_reg != `KCSB_ST_BIST);
  wire       isCmd = (rxData >= `KCSB_CMD_LEDS);
  wire       keyIn = keyValid && scanOn && !(keyPause && !keyMake);
  wire       repFire = repValid_reg && (repCnt_reg == 20'h0) && !txInhibit
                       && scanOn && !keyValid;

  assign txValid = !txInhibit && (respOut || !fifoEmpty || ovr_reg);
  assign txData  = respOut ? respQ_reg[7:0] : (!fifoEmpty ? fifoData : ovrCode);
  wire   txDone  = txValid && txReady;
  wire   fifoRd  = txDone && !respOut && !fifoEmpty;
  wire   ovrSent = txDone && !respOut && fifoEmpty;

  always @* begin
    pushData = 24'h0;
    pushCnt  = 2'h0;
    keyOvr   = 1'b0;
    wantSeq  = keyIn ? keySeq : repSeq_reg;
    wantLen  = keyIn ? keyLen : (repFire ? repLen_reg : 2'h0);
    if (!flush && wantLen != 2'h0 && !ovr_reg) begin
      if ({1'b0, fifoCount} + {4'h0, wantLen} > {1'b0, DEPTH}) begin
        keyOvr = 1'b1;
      end else begin
        pushData = wantSeq;
        pushCnt  = wantLen;
      end
    end
  end

  kcsb_fifo #(
    .WIDTH (8),
    .DEPTH (16),
    .AW    (4)
  ) uFifo (
    .clk    (clk),
    .rst_n  (rst_n),
    .flush  (flush),
    .wrData (pushData),
    .wrCnt  (pushCnt),
    .rdEn   (fifoRd),
    .rdData (fifoData),
    .empty  (fifoEmpty),
    .count  (fifoCount)
  );

  // ----------------------------------------
  // Flush requests from commands and at self-test start
  // ----------------------------------------
  always @* begin
    flush = 1'b0;
    if (cmdIn && isCmd) begin
      if (rxData == `KCSB_CMD_SETSEL || (rxData >= `KCSB_CMD_ENABLE
          && rxData <= `KCSB_CMD_TYPE_HI)) begin
        flush = 1'b1;
      end
    end else if (st_reg == `KCSB_ST_BIST && stCnt_reg == 20'h0) begin
      flush = 1'b1;
    end
  end

  // ----------------------------------------
  // Control sequencer and command interpreter
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg       <= `KCSB_ST_POR;
      stCnt_reg    <= 20'h0;
      enabled_reg  <= 1'b0;
      set_reg      <= `KCSB_SET_DEF;
      rate_reg     <= `KCSB_RATE_DEF;
      ledState_reg <= 3'h0;
      optKind_reg  <= 8'h00;
      respQ_reg    <= 24'h0;
      respCnt_reg  <= 2'h0;
      idBusy_reg   <= 1'b0;
      lastOut_reg  <= 8'h00;
      ovr_reg      <= 1'b0;
      repValid_reg <= 1'b0;
      repId_reg    <= 8'h00;
      repSeq_reg   <= 24'h0;
      repLen_reg   <= 2'h0;
      repCnt_reg   <= 20'h0;
    end else begin
      if (txDone && txData != `KCSB_RSP_RESEND) begin
        lastOut_reg <= txData;
      end
      if (txDone && respOut) begin
        respQ_reg   <= {8'h00, respQ_reg[23:8]};
        respCnt_reg <= respCnt_reg - 2'h1;
      end
      if (!respOut) begin
        idBusy_reg <= 1'b0;
      end
      if (keyOvr) begin
        ovr_reg <= 1'b1;
      end else if (ovrSent || flush) begin
        ovr_reg <= 1'b0;
      end
      // Typematic key tracking
      if (keyIn && keyMake && !keyPause) begin
        repValid_reg <= 1'b1;
        repId_reg    <= keyId;
        repSeq_reg   <= keySeq;
        repLen_reg   <= keyLen;
        repCnt_reg   <= delayUs[19:0];
      end else if (keyIn && !keyMake && keyId == repId_reg) begin
        repValid_reg <= 1'b0;
      end else if (repFire) begin
        repCnt_reg <= periodUs[19:0];
      end else if (usTick && repCnt_reg != 20'h0) begin
        repCnt_reg <= repCnt_reg - 20'h1;
      end
      if (flush) begin
        repValid_reg <= 1'b0;
      end
      case (st_reg)
        `KCSB_ST_POR: begin
          if (usTick) begin
            stCnt_reg <= stCnt_reg + 20'h1;
          end
          if (stCnt_reg >= POR_CNT) begin
            st_reg    <= `KCSB_ST_BIST;
            stCnt_reg <= 20'h0;
          end
        end
        `KCSB_ST_BIST: begin
          enabled_reg <= 1'b0;
          if (usTick) begin
            stCnt_reg <= stCnt_reg + 20'h1;
          end
          if (stCnt_reg == 20'h0) begin
            rate_reg     <= `KCSB_RATE_DEF;
            ledState_reg <= 3'h0;
          end
          if (stCnt_reg >= BIST_CNT) begin
            st_reg      <= `KCSB_ST_RUN;
            stCnt_reg   <= 20'h0;
            set_reg     <= `KCSB_SET_DEF;
            respCnt_reg <= 2'h1;
            enabled_reg <= bistPass;
            respQ_reg   <= {16'h0, bistPass ? `KCSB_RSP_PASS : `KCSB_RSP_FAIL};
          end
        end
        `KCSB_ST_RSTW: begin
          if (!respOut && linkIdle_reg) begin
            if (usTick) begin
              stCnt_reg <= stCnt_reg + 20'h1;
            end
          end else begin
            stCnt_reg <= 20'h0;
          end
          if (stCnt_reg >= ACC_CNT) begin
            st_reg    <= `KCSB_ST_BIST;
            stCnt_reg <= 20'h0;
          end
        end
        default: begin
        end
      endcase
      // Host bytes; a new byte replaces any unsent response
      if (cmdIn) begin
        st_reg      <= `KCSB_ST_RUN;
        stCnt_reg   <= 20'h0;
        respQ_reg   <= {16'h0, `KCSB_RSP_ACK};
        respCnt_reg <= 2'h1;
        if (st_reg == `KCSB_ST_OPT && !isCmd) begin
          if (optKind_reg == `KCSB_CMD_SETSEL) begin
            if (rxData == `KCSB_OPT_QUERY) begin
              respQ_reg   <= {8'h00, 6'h00, set_reg, `KCSB_RSP_ACK};
              respCnt_reg <= 2'h2;
            end else if (rxData <= `KCSB_OPT_SET_MAX) begin
              set_reg <= rxData[1:0];
            end
          end else if (optKind_reg == `KCSB_CMD_RATE) begin
            rate_reg <= rxData[6:0];
          end else begin
            ledState_reg <= rxData[2:0];
          end
        end else begin
          case (rxData)
            `KCSB_CMD_LEDS, `KCSB_CMD_RATE, `KCSB_CMD_SETSEL: begin
              st_reg      <= `KCSB_ST_OPT;
              optKind_reg <= rxData;
            end
            `KCSB_CMD_ECHO: begin
              respQ_reg <= {16'h0, `KCSB_RSP_ECHO};
            end
            `KCSB_CMD_BAD0, `KCSB_CMD_BAD1: begin
              respQ_reg <= {16'h0, `KCSB_RSP_RESEND};
            end
            `KCSB_CMD_IDENT: begin
              respQ_reg   <= {ID_CODE[15:8], ID_CODE[7:0], `KCSB_RSP_ACK};
              respCnt_reg <= 2'h3;
              idBusy_reg  <= 1'b1;
            end
            `KCSB_CMD_ENABLE: begin
              enabled_reg <= 1'b1;
            end
            `KCSB_CMD_DEFDIS: begin
              enabled_reg <= 1'b0;
              rate_reg    <= `KCSB_RATE_DEF;
            end
            `KCSB_CMD_DEFAULT: begin
              rate_reg <= `KCSB_RATE_DEF;
            end
            `KCSB_CMD_RESEND: begin
              respQ_reg <= {16'h0, lastOut_reg};
            end
            `KCSB_CMD_RESET: begin
              enabled_reg <= 1'b0;
              st_reg      <= `KCSB_ST_RSTW;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  assign leds           = (st_reg == `KCSB_ST_BIST) ? 3'h7 : ledState_reg;
  assign scanEnabled    = enabled_reg;
  assign scanSet        = set_reg;
  assign selfTestActive = (st_reg == `KCSB_ST_BIST) || (st_reg == `KCSB_ST_POR);

endmodule // kcsb_keyboard_cmd

// ### dv/kcsb_props.sv
// Purpose: Port assertions for the keyboard command block
// Assumes: Watches the top module ports only
// Notes:   Bound to the design after the module
`timescale 1ns/1ps
module kcsb_props (
  input wire       clk,
  input wire       rst_n,
  input wire       rxValid,
  input wire [7:0] rxData,
  input wire       txValid,
  input wire [7:0] txData,
  input wire       txReady,
  input wire       txInhibit,
  input wire       bistPass,
  input wire [2:0] leds,
  input wire       scanEnabled,
  input wire [1:0] scanSet,
  input wire       selfTestActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rxOk = rxValid && !selfTestActive && !txInhibit;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_no_tx_inh; txInhibit |-> !txValid; endproperty
  a_no_tx_inh: assert property (p_no_tx_inh) else $error("byte offered while inhibited");
  property p_hold;
    txValid && !txReady && !rxValid && !txInhibit |=> txInhibit || (txValid && $stable(txData));
  endproperty
  a_hold: assert property (p_hold) else $error("offered byte not held");
  property p_ack;
    rxOk && (rxData == 8'hF4 || rxData == 8'hF5 || rxData == 8'hF2) |=> txValid && txData == 8'hFA;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge missing");
  property p_echo; rxOk && rxData == 8'hEE |=> txValid && txData == 8'hEE; endproperty
  a_echo: assert property (p_echo) else $error("echo reply missing");
  property p_bad;
    rxOk && (rxData == 8'hEF || rxData == 8'hF1) |=> txData == 8'hFE && $stable(scanEnabled);
  endproperty
  a_bad: assert property (p_bad) else $error("invalid command handling wrong");
  property p_enable; rxValid && !selfTestActive && rxData == 8'hF4 |-> ##[1:2] scanEnabled; endproperty
  a_enable: assert property (p_enable) else $error("enable did not start scanning");
  property p_defdis; rxValid && !selfTestActive && rxData == 8'hF5 |-> ##[1:2] !scanEnabled; endproperty
  a_defdis: assert property (p_defdis) else $error("default disable kept scanning");
  property p_bist_end; $fell(selfTestActive) |-> $past(leds) == 3'h7 && leds == 3'h0; endproperty
  a_bist_end: assert property (p_bist_end) else $error("self-test lamps wrong");
  property p_bist_res; $fell(selfTestActive) |-> ##[0:2] (scanEnabled == bistPass); endproperty
  a_bist_res: assert property (p_bist_res) else $error("scan state after self-test wrong");
  property p_set_def; $rose(rst_n) |-> scanSet == 2'h2; endproperty
  a_set_def: assert property (p_set_def) else $error("default scan set wrong");
  c_ident: cover property (rxOk && rxData == 8'hF2);
  c_bist: cover property ($fell(selfTestActive));
  c_ovr: cover property (txValid && txReady && txData == 8'h00);
endmodule // kcsb_props
bind kcsb_keyboard_cmd kcsb_props kcsb_props_inst (
  .clk(clk), .rst_n(rst_n), .rxValid(rxValid), .rxData(rxData), .txValid(txValid),
  .txData(txData), .txReady(txReady), .txInhibit(txInhibit), .bistPass(bistPass),
  .leds(leds), .scanEnabled(scanEnabled), .scanSet(scanSet),
  .selfTestActive(selfTestActive));

// ### dv/kcsb_host_model.sv
// Purpose: Host controller model taking bytes from the block
// Assumes: Byte handshake; link lines pulled high when idle
// Notes:   slow stretches each byte over an eleven-bit link frame
`timescale 1ns/1ps
module kcsb_host_model (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       slow,
  input  wire       txValid,
  input  wire [7:0] txData,
  output logic      txReady,
  output wire       linkClkIn,
  output wire       linkDataIn
);
  int cnt = 0;
  initial txReady = 1'b0;
  // Frame per byte, byte taken at its end
  always @(posedge clk) begin
    #1;
    if (!rst_n || txValid !== 1'b1 || txReady) begin
      cnt = 0;
      txReady = 1'b0;
    end else begin
      cnt = cnt + 1;
      txReady = (cnt >= (slow ? 88 : 1));
    end
  end
  // Clock only within a frame, both lines idle high
  assign linkClkIn  = (cnt == 0) ? 1'b1 : cnt[2];
  assign linkDataIn = (cnt == 0) ? 1'b1 : txData[cnt[5:3]];
endmodule // kcsb_host_model

// ### dv/test_keyboard_command_scan_buffer.sv
// Purpose: Self-checking bench of the keyboard command block
// Assumes: Shortened timing parameters, fast or slow host model
// Notes:   Bytes taken by the host are logged with their cycle
`timescale 1ns/1ps
module test_keyboard_command_scan_buffer;
  logic        clk = 0, rst_n = 0, keyValid = 0, keyMake = 0, keyPause = 0;
  logic [7:0]  keyId = 0, rxData = 0;
  logic [23:0] keySeq = 0;
  logic [1:0]  keyLen = 0;
  logic        rxValid = 0, txInhibit = 0, bistPass = 1, slow = 0;
  wire         txValid, txReady, linkClkIn, linkDataIn, scanEnabled, selfTestActive;
  wire [7:0]   txData;
  wire [2:0]   leds;
  wire [1:0]   scanSet;
  int          fails = 0, n_tests = 0, cyc = 0, tLast = 0, tRel = 0;
  logic [7:0]  got[$];
  int          gotT[$];
  always #10 clk = ~clk;
  kcsb_keyboard_cmd #(.CYC_PER_US(2), .POR_US(20), .BIST_US(30), .DELAY_UNIT_US(25),
    .PERIOD_UNIT_US(4)) kcsb_keyboard_cmd_inst (
    .clk(clk), .rst_n(rst_n), .keyValid(keyValid), .keyMake(keyMake), .keyPause(keyPause),
    .keyId(keyId), .keySeq(keySeq), .keyLen(keyLen), .rxValid(rxValid), .rxData(rxData),
    .txValid(txValid), .txData(txData), .txReady(txReady), .txInhibit(txInhibit),
    .linkClkIn(linkClkIn), .linkDataIn(linkDataIn), .bistPass(bistPass), .leds(leds),
    .scanEnabled(scanEnabled), .scanSet(scanSet), .selfTestActive(selfTestActive));
  kcsb_host_model kcsb_host_model_inst (.clk(clk), .rst_n(rst_n), .slow(slow),
    .txValid(txValid), .txData(txData), .txReady(txReady), .linkClkIn(linkClkIn),
    .linkDataIn(linkDataIn));
  // ----------------------------------------
  // Byte log and cycle ceiling
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (txValid === 1'b1 && txReady === 1'b1) begin
      got.push_back(txData);
      gotT.push_back(cyc);
    end
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic check(string what, logic [7:0] exp, logic [7:0] act);
    n_tests++;
    if (act !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, act);
    end
  endtask
  task automatic expect_byte(logic [7:0] exp);
    int w;
    w = 0;
    while (got.size() == 0 && w < 3000) begin
      @(posedge clk);
      #1;
      w++;
    end
    if (got.size() == 0) check("byte", exp, 8'hXX);
    else begin
      tLast = gotT.pop_front();
      check("byte", exp, got.pop_front());
    end
  endtask
  task automatic quiet(int n);
    repeat (n) @(posedge clk);
    #1;
    check("extra bytes", 8'h00, 8'(got.size()));
  endtask
  task automatic send(logic [7:0] b);
    @(posedge clk);
    #1;
    rxValid = 1;
    rxData = b;
    @(posedge clk);
    #1;
    rxValid = 0;
  endtask
  task automatic key(logic mk, logic [7:0] id, logic [23:0] seq, logic [1:0] len);
    @(posedge clk);
    #1;
    keyValid = 1;
    keyMake = mk;
    keyId = id;
    keySeq = seq;
    keyLen = len;
    @(posedge clk);
    #1;
    keyValid = 0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic power_up();
    expect_byte(8'hAA);
    check("completion time", 8'h01, 8'(tLast - tRel >= 100 && tLast - tRel <= 110));
    check("scanEnabled", 8'h01, {7'h00, scanEnabled});
  endtask
  task automatic cmd_table();
    logic [7:0] c[10] = '{8'hEE, 8'hEF, 8'hF1, 8'hED, 8'hF3, 8'hF7, 8'hFD, 8'hF6, 8'hF5, 8'hF4};
    logic [7:0] r[10] = '{8'hEE, 8'hFE, 8'hFE, 8'hFA, 8'hFA, 8'hFA, 8'hFA, 8'hFA, 8'hFA, 8'hFA};
    foreach (c[i]) begin
      send(c[i]);
      expect_byte(r[i]);
    end
    check("scanEnabled", 8'h01, {7'h00, scanEnabled});
  endtask
  task automatic keys_and_resend();
    key(1, 8'h11, 24'h0074E0, 2);
    expect_byte(8'hE0);
    expect_byte(8'h74);
    key(0, 8'h11, 24'h74F0E0, 3);
    expect_byte(8'hE0);
    expect_byte(8'hF0);
    expect_byte(8'h74);
    send(8'hEE);
    expect_byte(8'hEE);
    send(8'hFE);
    expect_byte(8'hEE);
    send(8'hEF);
    expect_byte(8'hFE);
    send(8'hFE);
    expect_byte(8'hEE);
  endtask
  task automatic identify();
    slow = 1;
    send(8'hF2);
    expect_byte(8'hFA);
    expect_byte(8'h12);
    expect_byte(8'h5A);
    slow = 0;
  endtask
  task automatic overflow(int n, logic [1:0] len);
    keyPause = 1;
    txInhibit = 1;
    for (int i = 0; i < n; i++) key(1, 8'h20 + 8'(i), {16'h0000, 8'h40 + 8'(i)}, 1);
    key(1, 8'h60, 24'h002211, len);
    quiet(10);
    txInhibit = 0;
    for (int i = 0; i < n; i++) expect_byte(8'h40 + 8'(i));
    expect_byte(8'h00);
    quiet(20);
    keyPause = 0;
  endtask
  task automatic typematic();
    int t0;
    send(8'hF4);
    expect_byte(8'hFA);
    key(1, 8'h33, 24'h00001C, 1);
    expect_byte(8'h1C);
    t0 = tLast;
    expect_byte(8'h1C);
    check("delay", 8'h01, 8'(tLast - t0 >= 95 && tLast - t0 <= 106));
    t0 = tLast;
    expect_byte(8'h1C);
    check("period", 8'h01, 8'(tLast - t0 >= 170 && tLast - t0 <= 182));
    key(1, 8'h34, 24'h00001B, 1);
    expect_byte(8'h1B);
    key(0, 8'h34, 24'h001BF0, 2);
    expect_byte(8'hF0);
    expect_byte(8'h1B);
    quiet(400);
    key(0, 8'h33, 24'h001CF0, 2);
    txInhibit = 1;
    key(1, 8'h35, 24'h000015, 1);
    repeat (400) @(posedge clk);
    key(0, 8'h35, 24'h0015F0, 2);
    txInhibit = 0;
    expect_byte(8'hF0);
    expect_byte(8'h1C);
    expect_byte(8'h15);
    expect_byte(8'hF0);
    expect_byte(8'h15);
    quiet(50);
  endtask
  task automatic scan_set();
    send(8'hF0);
    expect_byte(8'hFA);
    send(8'h03);
    expect_byte(8'hFA);
    check("scanSet", 8'h03, {6'h00, scanSet});
    send(8'hF0);
    expect_byte(8'hFA);
    send(8'h00);
    expect_byte(8'hFA);
    expect_byte(8'h03);
    send(8'hED);
    expect_byte(8'hFA);
    send(8'h05);
    expect_byte(8'hFA);
    check("leds", 8'h05, {5'h00, leds});
    check("scanEnabled", 8'h01, {7'h00, scanEnabled});
  endtask
  task automatic reset_cmd();
    int t0;
    bistPass = 0;
    send(8'hFF);
    expect_byte(8'hFA);
    t0 = tLast;
    expect_byte(8'hFC);
    check("reset time", 8'h01, 8'(tLast - t0 >= 1055 && tLast - t0 <= 1070));
    check("scanEnabled", 8'h00, {7'h00, scanEnabled});
    check("leds", 8'h00, {5'h00, leds});
    bistPass = 1;
    send(8'hFF);
    expect_byte(8'hFA);
    expect_byte(8'hAA);
    check("scanSet", 8'h02, {6'h00, scanSet});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1;
    tRel = cyc;
    power_up();
    cmd_table();
    keys_and_resend();
    identify();
    overflow(16, 1);
    overflow(15, 2);
    typematic();
    scan_set();
    reset_cmd();
    tally_and_finish();
  end
endmodule // test_keyboard_command_scan_buffer
